// ===== pkg/timer_pkg.sv
package timer_pkg;

  // Register map, byte addresses on the APB
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFF_CNT_LO = 8'h00;
  localparam logic [7:0]  OFF_CNT_HI = 8'h04;
  localparam logic [7:0]  OFF_CTRL   = 8'h08;
  localparam logic [7:0]  OFF_GATE   = 8'h0C;
  localparam logic [7:0]  OFF_STAT   = 8'h10;
  localparam logic [7:0]  OFF_MASK   = 8'h14;

  // Field positions in timer_control_reg, gate_control_reg and status/mask
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_SYNC_DIS = 2;
  localparam int CTRL_XTAL_EN  = 3;
  localparam int CTRL_PS_LSB   = 4;
  localparam int CTRL_CS_LSB   = 6;
  localparam int GATE_EN_BIT   = 7;
  localparam int STAT_OVF      = 0;

  // Writable bits of timer_control_reg; bit 1 is reserved and reads zero
  localparam logic [7:0] CTRL_WMASK = 8'hFD;
  localparam logic [7:0] CTRL_RST   = 8'h00;

  // Clock source codes of clock_source_field
  typedef enum logic [1:0] {
    SRC_INSTR = 2'b00,
    SRC_SYS   = 2'b01,
    SRC_EXT   = 2'b10,
    SRC_CPS   = 2'b11
  } clk_src_t;

  // Pin indices in the pin-input vector
  localparam logic [1:0] PIN_EXT  = 2'h0;
  localparam logic [1:0] PIN_XTAL = 2'h1;
  localparam logic [1:0] PIN_CPS  = 2'h2;
  localparam int         PIN_N    = 3;

  // Counting constants
  localparam int          PS_W       = 3;
  localparam logic [1:0]  PS_DIV8    = 2'h3;
  localparam logic [1:0]  PS_DIV1    = 2'h0;
  localparam logic [1:0]  PHASE_LAST = 2'h3;
  localparam logic [1:0]  PHASE_ONE  = 2'h1;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam logic [15:0] SYS_STEP   = 16'h0004;
  localparam logic [15:0] COUNT_RST  = 16'h0000;

endpackage

// ===== pkg/count_path_if.sv
`timescale 1ns/1ps
// Signals between the timer core, its edge detector and its prescaler
interface count_path_if;
  logic [timer_pkg::PIN_N-1:0] src_pins;
  logic [1:0]                  src_idx;
  logic                        src_is_ext;
  logic                        rearm;
  logic                        edge_tick;
  logic                        tick_in;
  logic                        ps_clear;
  logic [1:0]                  ps_sel;
  logic                        ps_tick;

  modport top_mp  (output src_pins, src_idx, src_is_ext, rearm, tick_in, ps_clear, ps_sel,
                   input  edge_tick, ps_tick);
  modport edge_mp (input  src_pins, src_idx, src_is_ext, rearm,
                   output edge_tick);
  modport pre_mp  (input  tick_in, ps_clear, ps_sel,
                   output ps_tick);
endinterface

// ===== design/count_edge_detect.sv
`timescale 1ns/1ps
module count_edge_detect (
  input wire logic       pclk,
  input wire logic       presetn,
  count_path_if.edge_mp  cp
);

  typedef enum logic [1:0] {
    ARM_WAIT  = 2'b01,
    ARM_READY = 2'b10
  } arm_t;

  typedef struct packed {
    logic [timer_pkg::PIN_N-1:0] meta;
    logic [timer_pkg::PIN_N-1:0] sync;
    logic                        last;
    arm_t                        arm;
    logic                        tick;
  } edge_st_t;

  localparam edge_st_t EDGE_RST = '{'0, '0, 1'b0, ARM_WAIT, 1'b0};

  edge_st_t s_q;
  edge_st_t s_d;
  logic     level;

  // Every pin gets its own two stages; the source mux only sees second-stage levels
  always_comb begin
    s_d      = s_q;
    s_d.meta = cp.src_pins;
    s_d.sync = s_q.meta;
    level    = s_q.sync[cp.src_idx];
    s_d.last = level;
    s_d.tick = 1'b0;
    unique case (s_q.arm)
      ARM_WAIT: begin
        // A falling edge must be seen before a rising edge may count
        if (!cp.rearm && cp.src_is_ext && s_q.last && !level) begin
          s_d.arm = ARM_READY;
        end
      end
      ARM_READY: begin
        if (cp.rearm || !cp.src_is_ext) begin
          s_d.arm = ARM_WAIT;
        end else if (!s_q.last && level) begin
          s_d.tick = 1'b1;
        end
      end
      default: s_d.arm = ARM_WAIT;
    endcase
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= EDGE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign cp.edge_tick = s_q.tick;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_rise_delay: assert property (
    (s_q.tick && $stable(cp.src_idx) && ($past(cp.src_idx, 1) == $past(cp.src_idx, 2))
      && ($past(cp.src_idx, 2) == $past(cp.src_idx, 3))
      && ($past(cp.src_idx, 3) == $past(cp.src_idx, 4)))
    |-> ($past(cp.src_pins[cp.src_idx], 3) && !$past(cp.src_pins[cp.src_idx], 4)))
    else $error("counted edge without a rising pin three cycles back");

  a_fall_first: assert property (
    (s_q.arm == ARM_WAIT) |=> !s_q.tick)
    else $error("rising edge counted before a falling edge");

  a_rearm_blocks: assert property (
    cp.rearm |=> (s_q.arm == ARM_WAIT) ##1 !s_q.tick)
    else $error("edge detector not rearmed");

endmodule

// ===== design/prescale_div.sv
`timescale 1ns/1ps
module prescale_div #(
  parameter int PS_W = timer_pkg::PS_W
) (
  input wire logic      pclk,
  input wire logic      presetn,
  count_path_if.pre_mp  cp
);

  typedef struct packed {
    logic [PS_W-1:0] cnt;
  } ps_st_t;

  ps_st_t          s_q;
  ps_st_t          s_d;
  logic [PS_W-1:0] limit;

  // Terminal count for a divide of 1, 2, 4 or 8
  function automatic logic [PS_W-1:0] ps_limit(input logic [1:0] sel);
    ps_limit = PS_W'((1 << sel) - 1);
  endfunction

  // Divider; >= keeps it from running past a lowered limit
  always_comb begin
    s_d   = s_q;
    limit = ps_limit(cp.ps_sel);
    if (cp.ps_clear) begin
      s_d.cnt = '0;
    end else if (cp.tick_in) begin
      s_d.cnt = (s_q.cnt >= limit) ? '0 : s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cp.ps_tick = cp.tick_in && !cp.ps_clear && (s_q.cnt >= limit);

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_div8_tick;
    cp.tick_in && !cp.ps_clear && (cp.ps_sel == timer_pkg::PS_DIV8);
  endsequence

  a_div8_period: assert property (
    (cp.ps_tick && cp.ps_sel == timer_pkg::PS_DIV8) ##1 s_div8_tick [*7] ##1 s_div8_tick
    |-> cp.ps_tick)
    else $error("divide by eight did not fire on the eighth tick");

  a_div8_no_early: assert property (
    (cp.ps_tick && cp.ps_sel == timer_pkg::PS_DIV8) ##1 s_div8_tick |-> !cp.ps_tick)
    else $error("divide by eight fired early");

  a_clear_zero: assert property (
    cp.ps_clear |=> (s_q.cnt == '0))
    else $error("prescaler not cleared by count write");

endmodule

// ===== design/timer16_top.sv
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Sixteen-bit up-counter; writing either byte replaces that byte at once.
// - Run bit low stops it; gate-enable set limits counting to gate permit.
// - Source field picks instruction, system, capacitive or pin/crystal clock.
// - System clock source adds four counts per instruction cycle.
// - External sources count rising edges, synchronised or not.
// - External counting needs a falling edge first after reset, write or stop.
// - Prescaler divides the selected clock by one, two, four or eight.
// - Prescaler is invisible to software and cleared by any count write.
// - Crystal oscillator runs while its enable is set, also in sleep.
// - Sync-disable set counts external edges without instruction phase alignment.
// - Unsynchronised external counting continues in sleep and overflow raises interrupt.
// - Switching sync mode may lose or add a single count.
// - Rollover from all ones to zero sets overflow flag; software clears it.
// - Count byte reads always return a valid byte, even while counting.
module timer16_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [timer_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          external_count_pin,
  input  wire logic                          cps_osc_in,
  input  wire logic                          crystal_in_pin,
  output logic                               crystal_out_pin,
  input  wire logic                          gate_permit,
  input  wire logic                          sleep,
  output logic                               irq,
  output logic      [15:0]                   count_value
);

  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  ctrl;
    logic        gate_en;
    logic        ovf;
    logic        mask;
    logic [1:0]  phase;
    logic        pend;
    logic [31:0] rdata;
    logic        slverr;
    logic        xtal_out;
  } top_st_t;

  localparam top_st_t TOP_RST = '{
    timer_pkg::COUNT_RST, timer_pkg::CTRL_RST, 1'b0, 1'b0, 1'b0,
    2'h0, 1'b0, 32'h0000_0000, 1'b0, 1'b0};

  top_st_t             s_q;
  top_st_t             s_d;
  timer_pkg::clk_src_t src;
  logic                run;
  logic                sync_dis;
  logic                xtal_en;
  logic                async_ext;
  logic                gate_ok;
  logic                cnt_en;
  logic                instr_tick;
  logic                src_tick;
  logic                setup;
  logic                access;
  logic                wr_lo;
  logic                wr_hi;
  logic                wr_any;
  logic                stat_clr;
  logic                ovf_evt;
  logic [15:0]         cnt_inc;

  count_path_if cp ();

  // Known word-aligned register offsets
  function automatic logic reg_hit(input logic [timer_pkg::ADDR_W-1:0] a);
    reg_hit = (a == timer_pkg::OFF_CNT_LO) || (a == timer_pkg::OFF_CNT_HI) ||
              (a == timer_pkg::OFF_CTRL)   || (a == timer_pkg::OFF_GATE)   ||
              (a == timer_pkg::OFF_STAT)   || (a == timer_pkg::OFF_MASK);
  endfunction

  // Control fields
  assign src       = timer_pkg::clk_src_t'(s_q.ctrl[timer_pkg::CTRL_CS_LSB +: 2]);
  assign run       = s_q.ctrl[timer_pkg::CTRL_RUN];
  assign sync_dis  = s_q.ctrl[timer_pkg::CTRL_SYNC_DIS];
  assign xtal_en   = s_q.ctrl[timer_pkg::CTRL_XTAL_EN];
  assign async_ext = sync_dis && src[1];

  // APB phases; the slave never inserts wait states
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wr_lo    = access && pwrite && (paddr == timer_pkg::OFF_CNT_LO);
  assign wr_hi    = access && pwrite && (paddr == timer_pkg::OFF_CNT_HI);
  assign wr_any   = wr_lo || wr_hi;
  assign stat_clr = access && !pwrite && (paddr == timer_pkg::OFF_STAT)
                    && s_q.rdata[timer_pkg::STAT_OVF];

  // Count enable: run bit, optional gate, and sleep freezes all but async external
  assign gate_ok    = !s_q.gate_en || gate_permit;
  assign cnt_en     = run && gate_ok && (!sleep || async_ext);
  assign instr_tick = (s_q.phase == timer_pkg::PHASE_LAST);

  // Source clock selection before the prescaler
  always_comb begin
    unique case (src)
      timer_pkg::SRC_INSTR: src_tick = instr_tick;
      timer_pkg::SRC_SYS:   src_tick = 1'b1;
      timer_pkg::SRC_EXT,
      timer_pkg::SRC_CPS: begin
        // Synchronised mode waits for the instruction-cycle boundary
        src_tick = sync_dis ? cp.edge_tick
                            : ((s_q.pend || cp.edge_tick) && instr_tick);
      end
    endcase
  end

  // Pin routing to the edge detector; code 10 picks pin or crystal
  always_comb begin
    cp.src_pins = {cps_osc_in, crystal_in_pin, external_count_pin};
    if (src == timer_pkg::SRC_CPS) begin
      cp.src_idx = timer_pkg::PIN_CPS;
    end else if (xtal_en) begin
      cp.src_idx = timer_pkg::PIN_XTAL;
    end else begin
      cp.src_idx = timer_pkg::PIN_EXT;
    end
  end

  assign cp.src_is_ext = src[1];
  assign cp.rearm      = !run || wr_any;
  assign cp.tick_in    = src_tick && cnt_en;
  assign cp.ps_clear   = wr_any;
  assign cp.ps_sel     = s_q.ctrl[timer_pkg::CTRL_PS_LSB +: 2];

  count_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .cp      (cp.edge_mp)
  );

  prescale_div #(
    .PS_W (timer_pkg::PS_W)
  ) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .cp      (cp.pre_mp)
  );

  assign cnt_inc = s_q.count + timer_pkg::COUNT_ONE;
  assign ovf_evt = cp.ps_tick && !wr_any && (s_q.count == timer_pkg::COUNT_MAX);

  // Next state: counter, registers, interrupt flag and read data
  always_comb begin
    s_d       = s_q;
    s_d.phase = s_q.phase + timer_pkg::PHASE_ONE;
    // An edge that arrives mid-cycle waits for the boundary in synchronised mode
    s_d.pend  = (src[1] && !sync_dis) && (s_q.pend || cp.edge_tick) && !instr_tick;
    if (cp.ps_tick) begin
      s_d.count = cnt_inc;
    end
    // A byte write beats a concurrent increment
    if (wr_lo) begin
      s_d.count[7:0] = pwdata[7:0];
    end
    if (wr_hi) begin
      s_d.count[15:8] = pwdata[7:0];
    end
    if (access && pwrite && paddr == timer_pkg::OFF_CTRL) begin
      s_d.ctrl = pwdata[7:0] & timer_pkg::CTRL_WMASK;
    end
    if (access && pwrite && paddr == timer_pkg::OFF_GATE) begin
      s_d.gate_en = pwdata[timer_pkg::GATE_EN_BIT];
    end
    if (access && pwrite && paddr == timer_pkg::OFF_MASK) begin
      s_d.mask = pwdata[timer_pkg::STAT_OVF];
    end
    // Set wins over the read-clear; only a flag that was read is cleared
    s_d.ovf      = ovf_evt || (s_q.ovf && !stat_clr);
    s_d.xtal_out = xtal_en;
    // Read data captured in setup so the access phase needs no wait
    if (setup) begin
      s_d.slverr = !reg_hit(paddr);
      s_d.rdata  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          timer_pkg::OFF_CNT_LO: s_d.rdata[7:0] = s_q.count[7:0];
          timer_pkg::OFF_CNT_HI: s_d.rdata[7:0] = s_q.count[15:8];
          timer_pkg::OFF_CTRL:   s_d.rdata[7:0] = s_q.ctrl;
          timer_pkg::OFF_GATE:   s_d.rdata[timer_pkg::GATE_EN_BIT] = s_q.gate_en;
          timer_pkg::OFF_STAT:   s_d.rdata[timer_pkg::STAT_OVF] = s_q.ovf;
          timer_pkg::OFF_MASK:   s_d.rdata[timer_pkg::STAT_OVF] = s_q.mask;
          default:               s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign prdata          = s_q.rdata;
  assign pready          = 1'b1;
  assign pslverr         = access && s_q.slverr;
  assign irq             = s_q.ovf && s_q.mask;
  assign crystal_out_pin = s_q.xtal_out;
  assign count_value     = s_q.count;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rollover;
    cp.ps_tick && !wr_any && (s_q.count == timer_pkg::COUNT_MAX);
  endsequence

  sequence s_sys_run;
    (src == timer_pkg::SRC_SYS) && cnt_en && !wr_any && (cp.ps_sel == timer_pkg::PS_DIV1);
  endsequence

  a_count_lo_write: assert property (
    wr_lo |=> (s_q.count[7:0] == $past(pwdata[7:0])))
    else $error("low byte write not applied");

  a_stop_holds: assert property (
    (!run && !wr_any) |=> $stable(s_q.count))
    else $error("counter moved while stopped");

  a_gate_holds: assert property (
    (run && s_q.gate_en && !gate_permit && !wr_any) |=> $stable(s_q.count))
    else $error("counter moved while gate closed");

  a_instr_phase: assert property (
    ((src == timer_pkg::SRC_INSTR) && !instr_tick && !wr_any) |=> $stable(s_q.count))
    else $error("instruction clock counted off its cycle boundary");

  a_sys_four_step: assert property (
    s_sys_run [*4] |=> (s_q.count == $past(s_q.count, 4) + timer_pkg::SYS_STEP))
    else $error("system clock did not add four per instruction cycle");

  a_async_direct: assert property (
    (async_ext && cnt_en && cp.edge_tick) |-> cp.tick_in)
    else $error("unsynchronised edge not passed straight on");

  a_sleep_freeze: assert property (
    (sleep && !async_ext && !wr_any) |=> $stable(s_q.count))
    else $error("counter moved during sleep without async mode");

  a_sleep_counts: assert property (
    (sleep && async_ext && cp.ps_tick && !wr_any) |=> (s_q.count != $past(s_q.count)))
    else $error("async counter stalled during sleep");

  a_ovf_rollover: assert property (
    s_rollover |=> ((s_q.count == timer_pkg::COUNT_RST) && s_q.ovf))
    else $error("rollover did not wrap or set overflow flag");

  a_ovf_sticky: assert property (
    (s_q.ovf && !stat_clr) |=> s_q.ovf)
    else $error("overflow flag lost without a status read");

  a_xtal_follow: assert property (
    xtal_en ##1 xtal_en |-> crystal_out_pin)
    else $error("crystal amplifier not driven while enabled");

endmodule

// ===== verification/count_source_model.sv
`timescale 1ns/1ps
// Far side of the count inputs: slow clocks that stand low between bursts
module count_source_model (
  input  wire logic pclk,
  input  wire logic crystal_out_pin,
  output logic      ext_pin,
  output logic      cps_pin,
  output logic      xtal_pin
);
  logic [2:0] lvl_q;

  initial lvl_q = 3'h0;

  // Line 0 external pin, 1 capacitive oscillator, 2 crystal
  assign ext_pin  = lvl_q[0];
  assign cps_pin  = lvl_q[1];
  assign xtal_pin = lvl_q[2];

  // Each burst starts low, so its first edge is a rise; halves of six cycles
  task automatic pulses(input int sel, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge pclk);
      // No amplifier drive means the crystal cannot swing
      if (sel != 2 || crystal_out_pin === 1'h1) begin
        lvl_q[sel] <= ~lvl_q[sel];
      end
      repeat (5) @(posedge pclk);
    end
  endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, sleep, gate_permit, errv;
  logic        pready, pslverr, irq, crystal_out_pin, ext_pin, cps_pin, xtal_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] count_value, cnt_a;
  int          err_total, comparisons;

  // Every input settled at time zero
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep = 1'h0;
    gate_permit = 1'h0;
    err_total = 0;
    comparisons = 0;
  end

  always #50 pclk = ~pclk;

  timer16_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_pin(ext_pin), .cps_osc_in(cps_pin), .crystal_in_pin(xtal_pin),
    .crystal_out_pin(crystal_out_pin), .gate_permit(gate_permit), .sleep(sleep),
    .irq(irq), .count_value(count_value)
  );

  count_source_model i_src (
    .pclk(pclk), .crystal_out_pin(crystal_out_pin),
    .ext_pin(ext_pin), .cps_pin(cps_pin), .xtal_pin(xtal_pin)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; a dead slave is left to the watchdog, not to a local limit
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rdv, exp);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] src, input logic [1:0] ps,
                                      input logic sd, input logic xe, input logic run);
    return {24'h0, src, ps, xe, sd, 1'h0, run};
  endfunction

  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Reset values, a control read-back that leaves bit 1 clear, and an unmapped address
  task automatic t_reset();
    rd(timer_pkg::OFF_CTRL, 32'h0);
    rd(timer_pkg::OFF_CNT_LO, 32'h0);
    rd(timer_pkg::OFF_STAT, 32'h0);
    chk({31'h0, crystal_out_pin}, 32'h0);
    rd(8'h18, 32'h0);
    chk({31'h0, errv}, 32'h1);
    wr(timer_pkg::OFF_CTRL, 32'hF4);
    rd(timer_pkg::OFF_CTRL, 32'hF4);
    wr(timer_pkg::OFF_CTRL, 32'h0);
  endtask

  // Byte writes land at once and a stopped counter holds them
  task automatic t_bytes();
    wr(timer_pkg::OFF_CNT_HI, 32'h5A);
    wr(timer_pkg::OFF_CNT_LO, 32'hC3);
    rd(timer_pkg::OFF_CNT_HI, 32'h5A);
    cycles(20);
    chk({16'h0, count_value}, 32'h5AC3);
  endtask

  // Both internal sources at every prescale; window is eight whole divider periods
  task automatic t_rates();
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr(timer_pkg::OFF_CTRL, ctl(s[1:0], p[1:0], 1'h0, 1'h0, 1'h1));
        cycles(8);
        cnt_a = count_value;
        cycles((s == 0 ? 32 : 8) << p);
        chk({16'h0, count_value - cnt_a}, 32'h8);
      end
    end
    wr(timer_pkg::OFF_CTRL, 32'h0);
  endtask

  // A count write restarts the divide-by-eight from zero
  task automatic t_clear();
    wr(timer_pkg::OFF_CTRL, ctl(2'h1, 2'h3, 1'h0, 1'h0, 1'h1));
    cycles(5);
    wr(timer_pkg::OFF_CNT_LO, 32'h10);
    cycles(6);
    chk({24'h0, count_value[7:0]}, 32'h10);
    cycles(4);
    chk({24'h0, count_value[7:0]}, 32'h11);
    wr(timer_pkg::OFF_CTRL, 32'h0);
  endtask

  // Pin, capacitive and crystal sources; the first rise is lost for want of a fall
  task automatic t_ext();
    logic [1:0] src;
    for (int k = 0; k < 3; k++) begin
      src = (k == 1) ? 2'h3 : 2'h2;
      wr(timer_pkg::OFF_CTRL, ctl(src, 2'h0, k != 1, k == 2, 1'h0));
      wr(timer_pkg::OFF_CNT_HI, 32'h0);
      wr(timer_pkg::OFF_CNT_LO, 32'h0);
      cycles(4);
      chk({31'h0, crystal_out_pin}, {31'h0, k == 2});
      wr(timer_pkg::OFF_CTRL, ctl(src, 2'h0, k != 1, k == 2, 1'h1));
      i_src.pulses(k, 5);
      cycles(12);
      chk({16'h0, count_value}, 32'h4);
    end
    wr(timer_pkg::OFF_CTRL, 32'h0);
  endtask

  // Rollover sets the sticky flag; mask gates irq; a status read clears it
  task automatic t_ovf();
    wr(timer_pkg::OFF_CNT_HI, 32'hFF);
    wr(timer_pkg::OFF_CNT_LO, 32'hFC);
    wr(timer_pkg::OFF_MASK, 32'h1);
    wr(timer_pkg::OFF_CTRL, ctl(2'h1, 2'h0, 1'h0, 1'h0, 1'h1));
    cycles(10);
    wr(timer_pkg::OFF_CTRL, 32'h0);
    chk({24'h0, count_value[15:8]}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(timer_pkg::OFF_MASK, 32'h0);
    cycles(1); // Mask lands on the access edge; look once it has settled
    chk({31'h0, irq}, 32'h0);
    wr(timer_pkg::OFF_MASK, 32'h1);
    rd(timer_pkg::OFF_STAT, 32'h1);
    rd(timer_pkg::OFF_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  // Sleep freezes the internal timer but not unsynchronised pin counting
  task automatic t_sleep();
    wr(timer_pkg::OFF_CTRL, ctl(2'h1, 2'h0, 1'h0, 1'h0, 1'h1));
    sleep <= 1'h1;
    cycles(2);
    cnt_a = count_value;
    cycles(16);
    chk({16'h0, count_value}, {16'h0, cnt_a});
    sleep <= 1'h0;
    wr(timer_pkg::OFF_CTRL, 32'h0);
    wr(timer_pkg::OFF_CNT_HI, 32'hFF);
    wr(timer_pkg::OFF_CNT_LO, 32'hFF);
    wr(timer_pkg::OFF_CTRL, ctl(2'h2, 2'h0, 1'h1, 1'h0, 1'h1));
    sleep <= 1'h1;
    i_src.pulses(0, 2);
    cycles(12);
    chk({16'h0, count_value}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    sleep <= 1'h0;
    rd(timer_pkg::OFF_STAT, 32'h1);
    wr(timer_pkg::OFF_CTRL, 32'h0);
  endtask

  // With gate enable set, only the permit window lets counts through
  task automatic t_gate();
    wr(timer_pkg::OFF_GATE, 32'h80);
    rd(timer_pkg::OFF_GATE, 32'h80);
    wr(timer_pkg::OFF_CTRL, ctl(2'h1, 2'h0, 1'h0, 1'h0, 1'h1));
    cycles(2);
    cnt_a = count_value;
    cycles(16);
    chk({16'h0, count_value}, {16'h0, cnt_a});
    gate_permit <= 1'h1;
    cycles(2);
    cnt_a = count_value;
    cycles(16);
    chk({16'h0, count_value - cnt_a}, 32'h10);
    gate_permit <= 1'h0;
    wr(timer_pkg::OFF_CTRL, 32'h0);
  endtask

  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence after a twenty-cycle reset
  initial begin
    cycles(20);
    presetn <= 1'h1;
    t_reset();
    t_bytes();
    t_rates();
    t_clear();
    t_ext();
    t_ovf();
    t_sleep();
    t_gate();
    close_out();
  end

  // The whole run needs about twelve hundred cycles; this is far beyond it
  initial begin
    cycles(30000);
    err_total++;
    close_out();
  end
endmodule
